// file: cmm_core_map.sv
// core memory map decoder and core special register file
`timescale 1ns/1ns
`include "cmm_cfg.svh"
module cmm_core_map
  import cmm_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          arst_n_i,
  input  wire logic [15:0]   prog_addr_i,
  input  wire cmm_data_req_t data_req_i,
  input  wire logic [2:0]    bank_reg_i,
  output logic               prog_sel_o,
  output logic [13:0]        prog_rom_addr_o,
  output logic [7:0]         data_rdata_o,
  output logic               data_hit_o,
  output logic [7:0]         bank_reg_addr_o,
  output logic [15:0]        active_primary_data_pointer_o,
  output logic [7:0]         accum_o,
  output logic [7:0]         helper_o,
  output logic [7:0]         ext_op_o,
  output logic [7:0]         stack_o,
  output logic [7:0]         status_o,
  output cmm_mode_t          mode_o
);
  logic [7:0] stack_q;
  logic [7:0] dp0_low_q;
  logic [7:0] dp0_high_q;
  logic [7:0] dp1_low_q;
  logic [7:0] dp1_high_q;
  logic [7:0] mode_q;
  logic [7:0] status_q;
  logic [7:0] accum_q;
  logic [7:0] helper_q;
  logic [7:0] ext_op_q;
  logic [7:0] ram_rdata;
  logic       ram_sel;
  logic       sfr_sel;
  logic       ram_we;
  logic [7:0] sfr_rdata;
  logic       sfr_hit;

  // true when an address is in the upper half shared with registers
  function automatic logic is_upper(input logic [7:0] a);
    return a > `CMM_LOW_RAM_LAST;
  endfunction : is_upper

  // direct write strobe for one register offset
  function automatic logic sfr_wr(input cmm_data_req_t r, input logic [7:0] off);
    return r.wr && !r.indirect && (r.addr == off);
  endfunction : sfr_wr

  // program space decode: anything above the last byte is not selected
  assign prog_sel_o      = (prog_addr_i[15:14] == 2'b00);
  assign prog_rom_addr_o = prog_addr_i[13:0];

  // ram takes low half always, upper half only indirectly
  assign ram_sel = !is_upper(data_req_i.addr) || data_req_i.indirect;
  assign sfr_sel = is_upper(data_req_i.addr) && !data_req_i.indirect;
  assign ram_we  = data_req_i.wr && ram_sel;

  // 256 bytes, upper half physically apart from register space
  cmm_data_ram u_ram (
    .ref_clk_i (ref_clk_i),
    .we_i      (ram_we),
    .addr_i    (data_req_i.addr),
    .wdata_i   (data_req_i.wdata),
    .rdata_o   (ram_rdata)
  );

  // stack pointer
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stack_q <= `CMM_RST_STACK;
    end else if (sfr_wr(data_req_i, `CMM_OFF_STACK)) begin
      stack_q <= data_req_i.wdata;
    end
  end

  // primary data pointer bytes
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dp0_low_q  <= `CMM_RST_ZERO;
      dp0_high_q <= `CMM_RST_ZERO;
    end else begin
      if (sfr_wr(data_req_i, `CMM_OFF_DP0_LOW)) begin
        dp0_low_q <= data_req_i.wdata;
      end
      if (sfr_wr(data_req_i, `CMM_OFF_DP0_HIGH)) begin
        dp0_high_q <= data_req_i.wdata;
      end
    end
  end

  // second data pointer bytes
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dp1_low_q  <= `CMM_RST_ZERO;
      dp1_high_q <= `CMM_RST_ZERO;
    end else begin
      if (sfr_wr(data_req_i, `CMM_OFF_DP1_LOW)) begin
        dp1_low_q <= data_req_i.wdata;
      end
      if (sfr_wr(data_req_i, `CMM_OFF_DP1_HIGH)) begin
        dp1_high_q <= data_req_i.wdata;
      end
    end
  end

  // mode control keeps only its three storage bits
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q <= `CMM_RST_ZERO;
    end else if (sfr_wr(data_req_i, `CMM_OFF_MODE)) begin
      mode_q <= data_req_i.wdata & `CMM_MODE_MASK;
    end
  end

  // status word, bit 1 held at zero
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_q <= `CMM_RST_ZERO;
    end else if (sfr_wr(data_req_i, `CMM_OFF_STATUS)) begin
      status_q <= data_req_i.wdata & `CMM_STATUS_MASK;
    end
  end

  // accumulator, helper and extended operand
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      accum_q  <= `CMM_RST_ZERO;
      helper_q <= `CMM_RST_ZERO;
      ext_op_q <= `CMM_RST_ZERO;
    end else begin
      if (sfr_wr(data_req_i, `CMM_OFF_ACCUM)) begin
        accum_q <= data_req_i.wdata;
      end
      if (sfr_wr(data_req_i, `CMM_OFF_HELPER)) begin
        helper_q <= data_req_i.wdata;
      end
      if (sfr_wr(data_req_i, `CMM_OFF_EXT_OP)) begin
        ext_op_q <= data_req_i.wdata;
      end
    end
  end

  // register read mux; unassigned offsets hold nothing and read a fixed value
  always_comb begin
    sfr_hit   = 1'b1;
    sfr_rdata = `CMM_UNMAPPED_READ;
    unique case (data_req_i.addr)
      `CMM_OFF_STACK:    sfr_rdata = stack_q;
      `CMM_OFF_DP0_LOW:  sfr_rdata = dp0_low_q;
      `CMM_OFF_DP0_HIGH: sfr_rdata = dp0_high_q;
      `CMM_OFF_DP1_LOW:  sfr_rdata = dp1_low_q;
      `CMM_OFF_DP1_HIGH: sfr_rdata = dp1_high_q;
      `CMM_OFF_MODE:     sfr_rdata = mode_q;
      `CMM_OFF_STATUS:   sfr_rdata = status_q;
      `CMM_OFF_ACCUM:    sfr_rdata = accum_q;
      `CMM_OFF_HELPER:   sfr_rdata = helper_q;
      `CMM_OFF_EXT_OP:   sfr_rdata = ext_op_q;
      default: begin
        sfr_hit   = 1'b0;
        sfr_rdata = `CMM_UNMAPPED_READ;
      end
    endcase
  end

  // combinational read path back to the core
  assign data_rdata_o = sfr_sel ? sfr_rdata : ram_rdata;
  assign data_hit_o   = ram_sel || sfr_hit;

  // working register address within the selected bank
  assign bank_reg_addr_o = {3'b000, status_q[`CMM_STATUS_BANK_HI:`CMM_STATUS_BANK_LO],
                            bank_reg_i};

  // pointer select for all pointer instructions
  assign active_primary_data_pointer_o = mode_q[`CMM_MODE_DPSEL] ? {dp1_high_q, dp1_low_q}
                                                 : {dp0_high_q, dp0_low_q};

  // decoded mode bits and status bank bits for the execution unit, one driver for the whole struct
  assign mode_o = '{mul16:  mode_q[`CMM_MODE_MUL16],
                    div16:  mode_q[`CMM_MODE_DIV16],
                    dp_sel: mode_q[`CMM_MODE_DPSEL],
                    bank:   status_q[`CMM_STATUS_BANK_HI:`CMM_STATUS_BANK_LO]};
  // register views for the execution unit
  assign accum_o       = accum_q;
  assign helper_o      = helper_q;
  assign ext_op_o      = ext_op_q;
  assign stack_o       = stack_q;
  assign status_o      = status_q;
endmodule : cmm_core_map

// file: cmm_cfg.svh
// register offsets, reset values and field positions for the core memory map
`ifndef CMM_CFG_SVH
`define CMM_CFG_SVH
`define CMM_PROG_LAST      14'h3FFF
`define CMM_LOW_RAM_LAST   8'h7F
`define CMM_OFF_STACK      8'h81
`define CMM_OFF_DP0_LOW    8'h82
`define CMM_OFF_DP0_HIGH   8'h83
`define CMM_OFF_DP1_LOW    8'h84
`define CMM_OFF_DP1_HIGH   8'h85
`define CMM_OFF_MODE       8'h86
`define CMM_OFF_STATUS     8'hD0
`define CMM_OFF_ACCUM      8'hE0
`define CMM_OFF_HELPER     8'hF0
`define CMM_OFF_EXT_OP     8'hF1
`define CMM_RST_STACK      8'h07
`define CMM_RST_ZERO       8'h00
`define CMM_MODE_MASK      8'h0D
`define CMM_STATUS_MASK    8'hFD
`define CMM_MODE_DPSEL     0
`define CMM_MODE_MUL16     2
`define CMM_MODE_DIV16     3
`define CMM_STATUS_BANK_LO 3
`define CMM_STATUS_BANK_HI 4
`define CMM_UNMAPPED_READ  8'h00
`endif

// file: cmm_pkg.sv
// types shared by the core memory map files
package cmm_pkg;
  // one data-space access from the core
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       indirect;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmm_data_req_t;
  // mode bits decoded from the mode control register, bank from the status word
  typedef struct packed {
    logic       mul16;
    logic       div16;
    logic       dp_sel;
    logic [1:0] bank;
  } cmm_mode_t;
endpackage : cmm_pkg

// file: cmm_data_ram.sv
// 256-byte internal data ram, write on clock, combinational read
`timescale 1ns/1ns
module cmm_data_ram
  import cmm_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       we_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem_q [0:255];
  // storage write, contents not reset
  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
  end
  assign rdata_o = mem_q[addr_i];
endmodule : cmm_data_ram

// file: cmm_core_map_checker.sv
// port assertions for the core memory map
`timescale 1ns/1ns
module cmm_core_map_checker
  import cmm_pkg::*;
(
  input wire logic          ref_clk_i,
  input wire logic          arst_n_i,
  input wire logic [15:0]   prog_addr_i,
  input wire cmm_data_req_t data_req_i,
  input wire logic [2:0]    bank_reg_i,
  input wire logic          prog_sel_o,
  input wire logic [13:0]   prog_rom_addr_o,
  input wire logic [7:0]    data_rdata_o,
  input wire logic          data_hit_o,
  input wire logic [7:0]    bank_reg_addr_o,
  input wire logic [15:0]   active_primary_data_pointer_o,
  input wire logic [7:0]    accum_o,
  input wire logic [7:0]    helper_o,
  input wire logic [7:0]    ext_op_o,
  input wire logic [7:0]    stack_o,
  input wire logic [7:0]    status_o,
  input wire cmm_mode_t     mode_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // direct access and direct write qualifiers
  wire logic       dir = !data_req_i.indirect;
  wire logic       dwr = data_req_i.wr && dir;
  wire logic [7:0] a   = data_req_i.addr;
  wire logic [7:0] wd  = data_req_i.wdata;
  prog_decode_a:
    assert property (prog_sel_o == (prog_addr_i <= 16'h3FFF) && prog_rom_addr_o == prog_addr_i[13:0])
    else $error("program decode wrong");
  accum_write_a:
    assert property (dwr && a == 8'hE0 |=> accum_o == $past(wd))
    else $error("accumulator write lost");
  stack_write_a:
    assert property (dwr && a == 8'h81 |=> stack_o == $past(wd))
    else $error("stack pointer write lost");
  mode_mask_a:
    assert property (dwr && a == 8'h86 |=> {mode_o.mul16, mode_o.div16, mode_o.dp_sel}
      == {$past(wd[2]), $past(wd[3]), $past(wd[0])})
    else $error("mode bits wrong");
  status_mask_a:
    assert property (dwr && a == 8'hD0 |=> status_o == ($past(wd) & 8'hFD))
    else $error("status write wrong");
  bank_addr_a:
    assert property (bank_reg_addr_o == {3'h0, status_o[4:3], bank_reg_i} && mode_o.bank == status_o[4:3])
    else $error("bank address wrong");
  indirect_iso_a:
    assert property (data_req_i.wr && !dir |=> $stable({accum_o, helper_o, stack_o, status_o}))
    else $error("indirect write reached registers");
  unused_write_a:
    assert property (dwr && a == 8'h87 |=> $stable({accum_o, helper_o, ext_op_o, stack_o, active_primary_data_pointer_o}))
    else $error("unassigned write changed state");
  unused_read_a:
    assert property (dir && a == 8'h87 |-> !data_hit_o && data_rdata_o == 8'h00)
    else $error("unassigned address hit");
  direct_read_a:
    assert property (dir && a == 8'hE0 |-> data_hit_o && data_rdata_o == accum_o)
    else $error("direct read wrong");
  // main scenarios reached
  cover property (dwr && a == 8'h86);
  cover property (data_req_i.wr && !dir);
  cover property (!prog_sel_o);
endmodule : cmm_core_map_checker

bind cmm_core_map cmm_core_map_checker u_chk (.*);

// file: cmm_core_model.sv
// core-side model issuing data-space requests
`timescale 1ns/1ns
module cmm_core_model
  import cmm_pkg::*;
(
  input  wire logic [7:0] rdata_i,
  input  wire logic       ref_clk_i,
  output cmm_data_req_t   req_o
);
  initial req_o = '0;
  // write held until the next edge takes it
  task automatic wr(input logic ind, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1 req_o = '{1'b0, 1'b1, ind, a, d};
  endtask : wr
  // read held up to the next edge and data taken there; write data inverted
  task automatic rd(input logic ind, input logic [7:0] a, output logic [7:0] q);
    @(posedge ref_clk_i);
    #1 req_o = '{1'b1, 1'b0, ind, a, ~req_o.wdata};
    @(posedge ref_clk_i);
    q = rdata_i;
  endtask : rd
endmodule : cmm_core_model

// file: cmm_core_map_tb.sv
// self-checking bench for the core memory map
`timescale 1ns/1ns
module cmm_core_map_tb;
  import cmm_pkg::*;
  typedef struct packed {
    logic       wind;
    logic       rind;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } cmm_row_t;
  logic          ref_clk_i;
  logic          arst_n_i = 1'b0;
  logic [15:0]   prog_addr_i = 16'h0000;
  logic [2:0]    bank_reg_i = 3'h5;
  cmm_data_req_t req;
  cmm_mode_t     mode;
  logic          prog_sel;
  logic          hit;
  logic [13:0]   rom;
  logic [7:0]    rdata, bank_addr, accum, helper, ext_op, stack, status, q;
  logic [15:0]   primary_data_pointer;
  int            bad_count, num_checks;
  logic [15:0]   pa [3] = '{16'h3FFF, 16'h4000, 16'h0000};
  cmm_row_t      rows [14] = '{
    '{1'b0, 1'b0, 8'hE0, 8'h55, 8'h55}, '{1'b0, 1'b0, 8'hF0, 8'hA5, 8'hA5},
    '{1'b0, 1'b0, 8'hF1, 8'h3C, 8'h3C}, '{1'b0, 1'b0, 8'h81, 8'h5A, 8'h5A},
    '{1'b0, 1'b0, 8'h82, 8'h11, 8'h11}, '{1'b0, 1'b0, 8'h83, 8'h22, 8'h22},
    '{1'b0, 1'b0, 8'h84, 8'h33, 8'h33}, '{1'b0, 1'b0, 8'h85, 8'h44, 8'h44},
    '{1'b0, 1'b0, 8'h86, 8'hFF, 8'h0D}, '{1'b0, 1'b0, 8'hD0, 8'hFF, 8'hFD},
    '{1'b0, 1'b1, 8'h10, 8'h77, 8'h77}, '{1'b1, 1'b1, 8'hE0, 8'h99, 8'h99},
    '{1'b1, 1'b0, 8'hF0, 8'hC3, 8'hA5}, '{1'b0, 1'b0, 8'h87, 8'h66, 8'h00}};

  cmm_core_model m (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .req_o(req));
  cmm_core_map dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .prog_addr_i(prog_addr_i),
    .data_req_i(req), .bank_reg_i(bank_reg_i), .prog_sel_o(prog_sel),
    .prog_rom_addr_o(rom), .data_rdata_o(rdata), .data_hit_o(hit),
    .bank_reg_addr_o(bank_addr), .active_primary_data_pointer_o(primary_data_pointer), .accum_o(accum),
    .helper_o(helper), .ext_op_o(ext_op), .stack_o(stack), .status_o(status),
    .mode_o(mode));

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // register values while reset is low
  task automatic chk_rst;
    check(stack, 16'h0007);
    check({accum, helper}, 16'h0000);
    check({ext_op, status}, 16'h0000);
    check({primary_data_pointer[7:0], 3'h0, mode}, 16'h0000);
  endtask : chk_rst
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // watchdog far beyond the roughly seventy cycles the tests take
  initial begin
    #20000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge ref_clk_i);
    chk_rst();
    #1 arst_n_i = 1'b1;
    $display("reset test done");
    // write then read back each row, back to back
    foreach (rows[i]) begin
      m.wr(rows[i].wind, rows[i].addr, rows[i].wdata);
      m.rd(rows[i].rind, rows[i].addr, q);
      check(q, rows[i].exp);
    end
    check(hit, 16'h0000);
    m.wr(1'b0, 8'hE0, 8'h12);
    m.rd(1'b1, 8'hE0, q);
    check(q, 16'h0099);
    $display("row test done");
    check(primary_data_pointer, 16'h4433);
    check({bank_addr, 3'h0, mode}, 16'h1D1F);
    m.wr(1'b0, 8'h86, 8'h00);
    m.rd(1'b0, 8'h86, q);
    check(primary_data_pointer, 16'h2211);
    check(q, 16'h0000);
    $display("pointer test done");
    foreach (pa[i]) begin
      @(posedge ref_clk_i);
      #1 prog_addr_i = pa[i];
      #1 check({rom, 1'b0, prog_sel}, {pa[i][13:0], 1'b0, pa[i] <= 16'h3FFF});
    end
    $display("program test done");
    @(posedge ref_clk_i);
    #1 arst_n_i = 1'b0;
    #1 chk_rst();
    repeat (2) @(posedge ref_clk_i);
    #1 arst_n_i = 1'b1;
    m.wr(1'b0, 8'h81, 8'h30);
    m.rd(1'b0, 8'h81, q);
    check(q, 16'h0030);
    $display("second reset test done");
    test_done();
  end
endmodule : cmm_core_map_tb
